// file: design/tmc_consts.vh
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH
// register offsets (byte addresses)
`define TMC_OFF_ENABLE   8'h00
`define TMC_OFF_RUN      8'h04
`define TMC_OFF_CTRL     8'h08
`define TMC_OFF_MODE     8'h0c
`define TMC_OFF_COUNT    8'h1c
`define TMC_OFF_CMP0     8'h20
`define TMC_OFF_CMP1     8'h24
`define TMC_OFF_CAP0     8'h28
`define TMC_OFF_CAP1     8'h2c
// enable register fields
`define TMC_EN_MODULE    7
`define TMC_EN_PSWITCH   0
// run register fields
`define TMC_RUN_PRESCALE 2
`define TMC_RUN_COUNT    0
// control register fields
`define TMC_CR_DBUF      7
`define TMC_CR_RSV_HI    6
`define TMC_CR_RSV_LO    5
`define TMC_CR_IDLE      3
`define TMC_CR_TRGEDGE   1
`define TMC_CR_STARTSEL  0
// mode register fields
`define TMC_MD_PAIRED    6
`define TMC_MD_SOFTCAP   5
`define TMC_MD_CAPM_HI   4
`define TMC_MD_CAPM_LO   3
`define TMC_MD_MCLR      2
`define TMC_MD_CLK_HI    1
`define TMC_MD_CLK_LO    0
// capture and clock codes
`define TMC_CAPM_RISE    2'b01
`define TMC_CAPM_BOTH    2'b10
`define TMC_CLK_PIN      2'b00
`define TMC_CLK_DIV1     2'b01
`define TMC_CLK_DIV4     2'b10
`define TMC_CLK_DIV16    2'b11
// reset values and counter/prescaler widths
`define TMC_CR_RESET     8'h00
`define TMC_MD_RESET     7'h20
`define TMC_CNT_W        16
`define TMC_PRE_W        4
`endif

// file: design/tmc_timer.v
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "tmc_consts.vh"
module tmc_timer (
  // clock and reset
  input  wire        CLK,
  input  wire        RST_N,
  // register port
  input  wire [7:0]  ADDR,
  input  wire [31:0] WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [31:0] RDATA,
  // pin and system
  input  wire        TIMER_INPUT_PIN,
  input  wire        IDLE_MODE,
  // status
  output reg  [15:0] COUNT,
  output reg         COUNTING
);

  reg  [7:0]  ctrl_reg;
  reg  [6:0]  mode_reg;
  reg         enable_reg;
  reg         pswitch_reg;
  reg         prun_reg;
  reg         run_reg;
  reg  [`TMC_CNT_W-1:0] cnt_reg;
  reg  [`TMC_CNT_W-1:0] cmp0_reg;
  reg  [`TMC_CNT_W-1:0] cmp1_reg;
  reg  [`TMC_CNT_W-1:0] cmp0_buf_reg;
  reg  [`TMC_CNT_W-1:0] cmp1_buf_reg;
  reg         cmp0_pend_reg;
  reg         cmp1_pend_reg;
  reg  [`TMC_CNT_W-1:0] cap0_reg;
  reg  [`TMC_CNT_W-1:0] cap1_reg;
  reg  [`TMC_PRE_W-1:0] pre_reg;
  reg         pin_s1_reg;
  reg         pin_s2_reg;
  reg         pin_d_reg;
  reg         armed_reg;
  reg  [31:0] rdata_next;
  reg         tick;
  reg         pre_tick1;
  reg         pre_tick4;
  reg         pre_tick16;

  // registers other than enable are unreachable while module is off
  wire acc_ok   = enable_reg;
  wire wr_en    = WR & (ADDR == `TMC_OFF_ENABLE);
  wire wr_run   = WR & acc_ok & (ADDR == `TMC_OFF_RUN);
  wire wr_ctrl  = WR & acc_ok & (ADDR == `TMC_OFF_CTRL);
  wire wr_mode  = WR & acc_ok & (ADDR == `TMC_OFF_MODE);
  wire wr_cmp0  = WR & acc_ok & (ADDR == `TMC_OFF_CMP0);
  wire wr_cmp1  = WR & acc_ok & (ADDR == `TMC_OFF_CMP1);

  wire dbuf_on  = ctrl_reg[`TMC_CR_DBUF] | pswitch_reg;
  wire paired   = mode_reg[`TMC_MD_PAIRED];
  wire [1:0] capm = mode_reg[`TMC_MD_CAPM_HI:`TMC_MD_CAPM_LO];
  wire [1:0] clks = mode_reg[`TMC_MD_CLK_HI:`TMC_MD_CLK_LO];

  wire pin_rise = pin_s2_reg & ~pin_d_reg;
  wire pin_fall = ~pin_s2_reg & pin_d_reg;
  // trigger edge chosen by control bit 1
  wire trg_edge = ctrl_reg[`TMC_CR_TRGEDGE] ? pin_fall : pin_rise;

  // idle stops the count clock unless kept running
  wire clk_gate = ~IDLE_MODE | ctrl_reg[`TMC_CR_IDLE];
  wire counting = run_reg & armed_reg & clk_gate;
  wire match1   = counting & tick & (cnt_reg == cmp1_reg);

  // soft capture when 0 written to bit 5
  wire soft_cap = wr_mode & ~WDATA[`TMC_MD_SOFTCAP];

  always @* begin
    pre_tick1  = prun_reg;
    pre_tick4  = prun_reg & (pre_reg[1:0] == 2'h3);
    pre_tick16 = prun_reg & (pre_reg == 4'hf);
    case (clks)
      `TMC_CLK_PIN:   tick = pin_rise;
      `TMC_CLK_DIV1:  tick = pre_tick1;
      `TMC_CLK_DIV4:  tick = pre_tick4;
      `TMC_CLK_DIV16: tick = pre_tick16;
      default:        tick = 1'b0;
    endcase
  end

  // pin synchroniser; first stage only feeds the second
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_d_reg  <= 1'b0;
    end else begin
      pin_s1_reg <= TIMER_INPUT_PIN;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end

  // configuration registers; writes while running are software's fault
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable_reg  <= 1'b0;
      pswitch_reg <= 1'b0;
      prun_reg    <= 1'b0;
      run_reg     <= 1'b0;
      ctrl_reg    <= `TMC_CR_RESET;
      mode_reg    <= `TMC_MD_RESET;
    end else begin
      if (wr_en) begin
        enable_reg  <= WDATA[`TMC_EN_MODULE];
        pswitch_reg <= WDATA[`TMC_EN_PSWITCH];
      end
      if (wr_run) begin
        prun_reg <= WDATA[`TMC_RUN_PRESCALE];
        run_reg  <= WDATA[`TMC_RUN_COUNT];
      end
      // bits 6-5 must be written zero; bits 4 and 2 always read zero
      if (wr_ctrl)
        ctrl_reg <= WDATA[7:0] & 8'h8b;
      if (wr_mode) begin
        mode_reg <= WDATA[6:0];
        mode_reg[`TMC_MD_SOFTCAP] <= 1'b1;
      end
    end
  end

  // prescaler, counter and start arming
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pre_reg   <= {`TMC_PRE_W{1'b0}};
      cnt_reg   <= {`TMC_CNT_W{1'b0}};
      armed_reg <= 1'b0;
    end else begin
      if (!prun_reg)
        pre_reg <= {`TMC_PRE_W{1'b0}};
      else
        pre_reg <= pre_reg + 4'h1;
      if (!run_reg) begin
        cnt_reg   <= {`TMC_CNT_W{1'b0}};
        armed_reg <= 1'b0;
      end else begin
        // soft start arms at once; trigger start waits for edge
        if (!ctrl_reg[`TMC_CR_STARTSEL] || trg_edge)
          armed_reg <= 1'b1;
        if (match1 && mode_reg[`TMC_MD_MCLR])
          cnt_reg <= {`TMC_CNT_W{1'b0}};
        else if (counting && tick)
          cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // compare registers with optional double buffer
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp0_reg      <= {`TMC_CNT_W{1'b0}};
      cmp1_reg      <= {`TMC_CNT_W{1'b0}};
      cmp0_buf_reg  <= {`TMC_CNT_W{1'b0}};
      cmp1_buf_reg  <= {`TMC_CNT_W{1'b0}};
      cmp0_pend_reg <= 1'b0;
      cmp1_pend_reg <= 1'b0;
    end else if (!dbuf_on) begin
      if (wr_cmp0)
        cmp0_reg <= WDATA[15:0];
      if (wr_cmp1)
        cmp1_reg <= WDATA[15:0];
      cmp0_pend_reg <= 1'b0;
      cmp1_pend_reg <= 1'b0;
    end else begin
      if (wr_cmp0) begin
        cmp0_buf_reg  <= WDATA[15:0];
        cmp0_pend_reg <= 1'b1;
      end
      if (wr_cmp1) begin
        cmp1_buf_reg  <= WDATA[15:0];
        cmp1_pend_reg <= 1'b1;
      end
      // transfer at match1 or while stopped; paired waits for both
      if (match1 || !run_reg) begin
        if (paired) begin
          if (cmp0_pend_reg && cmp1_pend_reg && !wr_cmp0 && !wr_cmp1) begin
            cmp0_reg      <= cmp0_buf_reg;
            cmp1_reg      <= cmp1_buf_reg;
            cmp0_pend_reg <= 1'b0;
            cmp1_pend_reg <= 1'b0;
          end
        end else begin
          if (cmp0_pend_reg && !wr_cmp0) begin
            cmp0_reg      <= cmp0_buf_reg;
            cmp0_pend_reg <= 1'b0;
          end
          if (cmp1_pend_reg && !wr_cmp1) begin
            cmp1_reg      <= cmp1_buf_reg;
            cmp1_pend_reg <= 1'b0;
          end
        end
      end
    end
  end

  // capture registers
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cap0_reg <= {`TMC_CNT_W{1'b0}};
      cap1_reg <= {`TMC_CNT_W{1'b0}};
    end else begin
      if (soft_cap ||
          (pin_rise && (capm == `TMC_CAPM_RISE || capm == `TMC_CAPM_BOTH)))
        cap0_reg <= cnt_reg;
      if (pin_fall && capm == `TMC_CAPM_BOTH)
        cap1_reg <= cnt_reg;
    end
  end

  // read mux; unused bits and blocked access read zero
  always @* begin
    rdata_next = 32'h00000000;
    if (ADDR == `TMC_OFF_ENABLE) begin
      rdata_next[`TMC_EN_MODULE]  = enable_reg;
      rdata_next[`TMC_EN_PSWITCH] = pswitch_reg;
    end else if (acc_ok) begin
      case (ADDR)
        `TMC_OFF_RUN: begin
          rdata_next[`TMC_RUN_PRESCALE] = prun_reg;
          rdata_next[`TMC_RUN_COUNT]    = run_reg;
        end
        `TMC_OFF_CTRL:  rdata_next[7:0]  = ctrl_reg;
        `TMC_OFF_MODE:  rdata_next[6:0]  = mode_reg;
        `TMC_OFF_COUNT: rdata_next[15:0] = cnt_reg;
        `TMC_OFF_CMP0:  rdata_next[15:0] = cmp0_reg;
        `TMC_OFF_CMP1:  rdata_next[15:0] = cmp1_reg;
        `TMC_OFF_CAP0:  rdata_next[15:0] = cap0_reg;
        `TMC_OFF_CAP1:  rdata_next[15:0] = cap1_reg;
        default:        rdata_next = 32'h00000000;
      endcase
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA    <= 32'h00000000;
      COUNT    <= 16'h0000;
      COUNTING <= 1'b0;
    end else begin
      RDATA    <= RD ? rdata_next : 32'h00000000;
      COUNT    <= cnt_reg;
      COUNTING <= counting;
    end
  end

endmodule // tmc_timer

// file: bench/tmc_pin_model.sv
`timescale 1ns/1ps
module tmc_pin_model (
  // timing
  input  wire CLK,
  // driven pin
  output reg  PIN
);
  initial PIN = 1'b0;
  // hold long enough for the pin synchroniser to see every level
  task drive(input logic v, input int hold);
    @(posedge CLK);
    PIN <= v;
    repeat (hold) @(posedge CLK);
  endtask
endmodule // tmc_pin_model

// file: bench/tmc_timer_asserts.sv
`timescale 1ns/1ps
module tmc_timer_asserts (
  input wire        CLK,
  input wire        RST_N,
  input wire [7:0]  ADDR,
  input wire [31:0] WDATA,
  input wire        WR,
  input wire        RD,
  input wire [31:0] RDATA,
  input wire        TIMER_INPUT_PIN,
  input wire        IDLE_MODE,
  input wire [15:0] COUNT,
  input wire        COUNTING
);
  reg en_q;
  reg idle_q;
  // shadows of what software wrote, for checks that depend on them
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      en_q   <= 1'b0;
      idle_q <= 1'b0;
    end else if (WR && ADDR == 8'h00) begin
      en_q <= WDATA[7];
    end else if (WR && en_q && ADDR == 8'h08) begin
      idle_q <= WDATA[3];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_ctrl_rd;
    RD && ADDR == 8'h08 |=> (RDATA & 32'hffffff74) == 32'h0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
  property p_mode_rd;
    RD && en_q && ADDR == 8'h0c |=> RDATA[5] && RDATA[31:7] == 25'h0;
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read");
  property p_off_rd;
    RD && !en_q && ADDR != 8'h00 |=> RDATA == 32'h0;
  endproperty
  a_off_rd: assert property (p_off_rd) else $error("off read");
  property p_hole_rd;
    RD && ADDR == 8'h40 |=> RDATA == 32'h0;
  endproperty
  a_hole_rd: assert property (p_hole_rd) else $error("hole read");
  property p_run_rd;
    RD && en_q && ADDR == 8'h04 |=> (RDATA & 32'hfffffffa) == 32'h0;
  endproperty
  a_run_rd: assert property (p_run_rd) else $error("run read");
  property p_stop;
    WR && en_q && ADDR == 8'h04 && !WDATA[0]
      |-> ##3 !COUNTING ##1 COUNT == 16'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("stop");
  property p_step;
    COUNT == $past(COUNT) || COUNT == $past(COUNT) + 16'h1
      || COUNT == 16'h0;
  endproperty
  a_step: assert property (p_step) else $error("count step");
  property p_idle;
    IDLE_MODE && !idle_q |=> !COUNTING;
  endproperty
  a_idle: assert property (p_idle) else $error("idle run");
  c_run: cover property (WR && ADDR == 8'h04 && WDATA[0]);
  c_idle: cover property (IDLE_MODE && COUNTING);
  c_cap: cover property (WR && ADDR == 8'h0c && !WDATA[5]);
endmodule // tmc_timer_asserts
bind tmc_timer tmc_timer_asserts u_tmc_timer_asserts (
  .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .TIMER_INPUT_PIN(TIMER_INPUT_PIN),
  .IDLE_MODE(IDLE_MODE), .COUNT(COUNT), .COUNTING(COUNTING));

// file: bench/tmc_timer_test.sv
`timescale 1ns/1ps
module tmc_timer_test;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         idle = 1'b0;
  wire [31:0] rdata;
  wire        pin;
  wire [15:0] count;
  wire        counting;
  reg  [31:0] v;
  reg  [31:0] w;
  integer     err_count = 0;
  integer     checks = 0;
  integer     cyc = 0;
  integer     i;
  always #2 clk = ~clk;
  tmc_timer u_tmc_timer (.CLK(clk), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .TIMER_INPUT_PIN(pin), .IDLE_MODE(idle), .COUNT(count),
    .COUNTING(counting));
  tmc_pin_model u_tmc_pin_model (.CLK(clk), .PIN(pin));
  task bus_wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task bus_rd(input [7:0] a, output [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks = checks + 1;
    if (s !== e) begin
      err_count = err_count + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(8'h08, v); chk(v, 32'h0);
    bus_wr(8'h00, 32'h80);
    bus_rd(8'h0c, v); chk(v, 32'h20);
    bus_rd(8'h08, v); chk(v, 32'h0);
    bus_wr(8'h08, 32'hff);
    bus_rd(8'h08, v); chk(v, 32'h8b);
    bus_wr(8'h00, 32'h0);
    bus_rd(8'h08, v); chk(v, 32'h0);
    bus_wr(8'h00, 32'h80);
    bus_rd(8'h08, v); chk(v, 32'h8b);
    bus_rd(8'h40, v); chk(v, 32'h0);
    bus_wr(8'h08, 32'h0);
    // taps 1, 4, 16 over 64 cycles; start-up latency allowed for
    for (i = 1; i < 4; i = i + 1) begin
      bus_wr(8'h0c, 32'h20 | i);
      bus_wr(8'h04, 32'h5);
      repeat (64) @(posedge clk);
      w = 64 >> (2 * i - 2);
      bus_rd(8'h1c, v); chk(v + 3 >= w && v <= w + 3, 1'b1);
      bus_wr(8'h04, 32'h0);
    end
    bus_wr(8'h0c, 32'h20);
    bus_wr(8'h04, 32'h5);
    for (i = 0; i < 6; i = i + 1) begin
      u_tmc_pin_model.drive(1'b1, 4);
      u_tmc_pin_model.drive(1'b0, 4);
    end
    bus_rd(8'h1c, v); chk(v, 32'h6);
    bus_wr(8'h04, 32'h0);
    bus_wr(8'h24, 32'h5);
    bus_wr(8'h0c, 32'h25);
    bus_wr(8'h04, 32'h5);
    w = 0;
    repeat (40) @(posedge clk) if (count > w) w = count;
    chk(w, 32'h5);
    bus_wr(8'h04, 32'h0);
    bus_wr(8'h0c, 32'h31);
    bus_wr(8'h04, 32'h5);
    u_tmc_pin_model.drive(1'b1, 10);
    u_tmc_pin_model.drive(1'b0, 10);
    bus_rd(8'h28, v);
    bus_rd(8'h2c, w); chk(w - v, 32'hb);
    // software capture taken while counting
    bus_wr(8'h0c, 32'h11);
    bus_rd(8'h28, v); chk(v > w, 1'b1);
    bus_wr(8'h04, 32'h0);
    bus_wr(8'h08, 32'h3);
    bus_wr(8'h04, 32'h5);
    u_tmc_pin_model.drive(1'b1, 10);
    chk(count, 32'h0);
    u_tmc_pin_model.drive(1'b0, 10);
    chk(count != 16'h0, 1'b1);
    idle <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(counting, 1'b0);
    bus_wr(8'h04, 32'h0);
    bus_wr(8'h08, 32'h8);
    bus_wr(8'h04, 32'h5);
    repeat (4) @(posedge clk);
    #1 chk(counting, 1'b1);
    idle <= 1'b0;
    bus_wr(8'h04, 32'h0);
    // double buffer: a write while running waits for the compare-1 match
    bus_wr(8'h08, 32'h80);
    bus_wr(8'h0c, 32'h21);
    bus_wr(8'h24, 32'h20);
    bus_wr(8'h04, 32'h5);
    bus_wr(8'h24, 32'h30);
    bus_rd(8'h24, v); chk(v, 32'h20);
    repeat (40) @(posedge clk);
    bus_rd(8'h24, v); chk(v, 32'h30);
    // paired update: compare 1 alone stays in its buffer
    bus_wr(8'h04, 32'h0);
    bus_wr(8'h0c, 32'h61);
    bus_wr(8'h04, 32'h5);
    bus_wr(8'h24, 32'h40);
    repeat (60) @(posedge clk);
    bus_rd(8'h24, v); chk(v, 32'h30);
    bus_wr(8'h20, 32'h10);
    bus_wr(8'h04, 32'h0);
    bus_rd(8'h24, v); chk(v, 32'h40);
    bus_rd(8'h20, v); chk(v, 32'h10);
    // power-switch mode buffers even with the control double-buffer bit clear
    bus_wr(8'h08, 32'h0);
    bus_wr(8'h0c, 32'h21);
    bus_wr(8'h00, 32'h81);
    bus_wr(8'h04, 32'h5);
    bus_wr(8'h24, 32'h50);
    bus_rd(8'h24, v); chk(v, 32'h40);
    bus_wr(8'h04, 32'h0);
    bus_wr(8'h00, 32'h80);
    tally_and_finish;
  end
endmodule // tmc_timer_test
